/* src/aro_pkg.sv */
`default_nettype none

package aro_pkg;

  // clock and conversion timing
  localparam int ARO_CLK_HZ = 125_000_000;
  localparam int ARO_RATE_10HZ = 10;
  localparam int ARO_RATE_OTHER = 40;
  localparam int ARO_PERIOD_10HZ = ARO_CLK_HZ / ARO_RATE_10HZ;
  localparam int ARO_PERIOD_OTHER = ARO_CLK_HZ / ARO_RATE_OTHER;

  // widths
  localparam int ARO_RES_W = 20;
  localparam int ARO_RAW_W = 24;
  localparam int ARO_CNT_W = 24;
  localparam int ARO_ADDR_W = 5;

  // output code limits
  localparam logic [19:0] ARO_CODE_MAX = 20'h7ffff;
  localparam logic [19:0] ARO_CODE_MIN = 20'h80000;
  localparam logic signed [23:0] ARO_RAW_MAX = 24'sh07ffff;
  localparam logic signed [23:0] ARO_RAW_MIN = 24'shf80000;

  // register byte offsets
  localparam logic [4:0] ARO_OFF_CTRL = 5'h00;
  localparam logic [4:0] ARO_OFF_STAT = 5'h04;
  localparam logic [4:0] ARO_OFF_MASK = 5'h08;
  localparam logic [4:0] ARO_OFF_RES_L = 5'h0c;
  localparam logic [4:0] ARO_OFF_RES_M = 5'h10;
  localparam logic [4:0] ARO_OFF_RES_H = 5'h14;

  // control selections and reset values
  localparam logic [2:0] ARO_RATE_SEL_10HZ = 3'h1;
  localparam logic [2:0] ARO_MODE_SEL_NORMAL = 3'h0;
  localparam logic [9:0] ARO_CTRL_RST = 10'h001;
  localparam logic [1:0] ARO_STAT_RST = 2'h0;
  localparam logic [1:0] ARO_MASK_RST = 2'h0;

  // event bit positions in status and mask
  localparam int ARO_EV_DONE = 0;
  localparam int ARO_EV_CLIP = 1;

  typedef enum logic [1:0] {
    ARO_OFF = 2'b00,
    ARO_SLEEP = 2'b01,
    ARO_RESTART = 2'b10,
    ARO_RUN = 2'b11
  } aro_mode_type;

  // control register, bit 0 is power off
  typedef struct packed {
    logic [2:0] filter_mode_select;
    logic [2:0] output_rate_select;
    logic result_hold_enable;
    logic converter_restart;
    logic converter_sleep;
    logic converter_power_off;
  } aro_ctrl_type;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } aro_av_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } aro_av_rsp_type;

endpackage

`default_nettype wire

/* src/aro_saturate.sv */
`timescale 1ns/1ps
`default_nettype none

// clamps the wide filter word into the 20-bit two's complement code
module aro_saturate
  import aro_pkg::*;
(
  // wide signed filter word
  input wire logic signed [23:0] raw_data,
  // clamped code
  output logic [19:0] code,
  output logic clipped
);

  // clamp instead of letting the upper bits wrap around
  always_comb begin
    if (raw_data > ARO_RAW_MAX) begin
      code = ARO_CODE_MAX;
      clipped = 1'b1;
    end else if (raw_data < ARO_RAW_MIN) begin
      code = ARO_CODE_MIN;
      clipped = 1'b1;
    end else begin
      code = raw_data[19:0];
      clipped = 1'b0;
    end
  end

endmodule

`default_nettype wire

/* src/aro_result_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module aro_result_ctrl
  import aro_pkg::*;
#(
  parameter int PERIOD_10HZ = ARO_PERIOD_10HZ,
  parameter int PERIOD_OTHER = ARO_PERIOD_OTHER
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire aro_av_req_type av_req,
  output var aro_av_rsp_type av_rsp,
  // decimation filter and analog controls
  input wire logic [23:0] filter_data,
  output var logic filter_reset,
  output var logic modulator_enable,
  output var logic pga_enable,
  // interrupt
  output var logic irq
);

  typedef struct packed {
    aro_ctrl_type ctrl;
    logic [1:0] stat;
    logic [1:0] mask;
    aro_mode_type mode;
    logic [23:0] cnt;
    logic [19:0] result;
    logic ack;
    logic [31:0] rdata;
    logic filt_rst;
  } aro_state_type;

  localparam logic [23:0] LAST_10HZ = 24'(PERIOD_10HZ - 1);
  localparam logic [23:0] LAST_OTHER = 24'(PERIOD_OTHER - 1);

  aro_state_type state_reg;
  aro_state_type state_next;
  logic [19:0] sat_code;
  logic sat_clip;
  logic req;
  logic done_wr;
  logic conv_end;
  logic [23:0] last_cnt;
  logic [7:0] high_byte;

  aro_saturate u_sat (
    .raw_data(filter_data),
    .code(sat_code),
    .clipped(sat_clip)
  );

  assign req = av_req.read | av_req.write;
  // high byte carries bits 19:16, sign-extended into the upper nibble
  assign high_byte = {{4{state_reg.result[19]}}, state_reg.result[19:16]};

  // conversion length follows the rate and filter selections
  always_comb begin
    if (state_reg.ctrl.output_rate_select == ARO_RATE_SEL_10HZ &&
        state_reg.ctrl.filter_mode_select == ARO_MODE_SEL_NORMAL) begin
      last_cnt = LAST_10HZ;
    end else begin
      last_cnt = LAST_OTHER;
    end
  end

  // at or past the end, so a shorter rate picked mid-count cannot overrun
  assign conv_end = (state_reg.mode == ARO_RUN) &&
                    (state_reg.cnt >= last_cnt);
  // write to status taking effect this edge with the done bit set
  assign done_wr = req && av_req.write && state_reg.ack &&
                   av_req.address == ARO_OFF_STAT &&
                   av_req.byteenable[0] && av_req.writedata[ARO_EV_DONE];

  // whole next-state computation
  always_comb begin
    state_next = state_reg;

    // bus: first cycle latches read data, second completes the access
    state_next.ack = req & ~state_reg.ack;
    if (req && !state_reg.ack && av_req.read) begin
      case (av_req.address)
        ARO_OFF_CTRL: state_next.rdata = {22'h0, state_reg.ctrl};
        ARO_OFF_STAT: state_next.rdata = {30'h0, state_reg.stat};
        ARO_OFF_MASK: state_next.rdata = {30'h0, state_reg.mask};
        ARO_OFF_RES_L: state_next.rdata = {24'h0, state_reg.result[7:0]};
        ARO_OFF_RES_M: state_next.rdata = {24'h0, state_reg.result[15:8]};
        ARO_OFF_RES_H: state_next.rdata = {24'h0, high_byte};
        default: state_next.rdata = 32'h0;
      endcase
    end

    // register writes land at the edge where waitrequest is low
    if (req && av_req.write && state_reg.ack) begin
      case (av_req.address)
        ARO_OFF_CTRL: begin
          if (av_req.byteenable[0]) begin
            state_next.ctrl[7:0] = av_req.writedata[7:0];
          end
          if (av_req.byteenable[1]) begin
            state_next.ctrl[9:8] = av_req.writedata[9:8];
          end
        end
        ARO_OFF_STAT: begin
          if (av_req.byteenable[0]) begin
            state_next.stat = state_reg.stat & ~av_req.writedata[1:0];
          end
        end
        ARO_OFF_MASK: begin
          if (av_req.byteenable[0]) begin
            state_next.mask = av_req.writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // operating mode; power off outranks sleep, sleep outranks restart
    if (state_reg.ctrl.converter_power_off) begin
      state_next.mode = ARO_OFF;
    end else if (state_reg.ctrl.converter_sleep) begin
      state_next.mode = ARO_SLEEP;
    end else if (state_reg.ctrl.converter_restart) begin
      state_next.mode = ARO_RESTART;
    end else begin
      // off bit clear powers the amplifier, but running waits for a restart
      case (state_reg.mode)
        ARO_RESTART: state_next.mode = ARO_RUN;
        ARO_RUN: state_next.mode = ARO_RUN;
        ARO_OFF: state_next.mode = ARO_SLEEP;
        ARO_SLEEP: state_next.mode = ARO_SLEEP;
        default: state_next.mode = ARO_OFF;
      endcase
    end
    state_next.filt_rst = (state_next.mode == ARO_RESTART);

    // conversion timer restarts from zero whenever not running
    if (state_reg.mode != ARO_RUN || conv_end) begin
      state_next.cnt = 24'h0;
    end else begin
      state_next.cnt = state_reg.cnt + 24'h1;
    end

    // store a result; hold discards it with no flag and no interrupt
    if (conv_end && !state_reg.ctrl.result_hold_enable) begin
      state_next.result = sat_code;
      state_next.stat[ARO_EV_DONE] = 1'b1;
      if (sat_clip) begin
        state_next.stat[ARO_EV_CLIP] = 1'b1;
      end
    end
  end

  // single register for all state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.ctrl <= aro_ctrl_type'(ARO_CTRL_RST);
      state_reg.stat <= ARO_STAT_RST;
      state_reg.mask <= ARO_MASK_RST;
      state_reg.mode <= ARO_OFF;
      state_reg.cnt <= 24'h0;
      state_reg.result <= 20'h0;
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0;
      state_reg.filt_rst <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs; waitrequest is combinational so idle cycles never stall
  assign av_rsp.waitrequest = req & ~state_reg.ack;
  assign av_rsp.readdata = state_reg.rdata;
  assign filter_reset = state_reg.filt_rst;
  assign pga_enable = (state_reg.mode != ARO_OFF);
  assign modulator_enable = (state_reg.mode == ARO_RESTART) ||
                            (state_reg.mode == ARO_RUN);
  assign irq = |(state_reg.stat & state_reg.mask);

  // checks on the clamp
  sat_pos_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $signed(filter_data) > ARO_RAW_MAX |-> sat_code == 20'h7ffff
  ) else $error("positive overrange not clamped");

  sat_neg_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $signed(filter_data) < ARO_RAW_MIN |-> sat_code == 20'h80000
  ) else $error("negative overrange not clamped");

  sat_pass_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !sat_clip |-> sat_code == filter_data[19:0]
  ) else $error("in-range word altered");

  sign_keep_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    sat_code[19] == filter_data[23]
  ) else $error("code sign differs from input sign");

  // conversion end and flag, restart, continuous run, 10 Hz length and bus wait
  done_set_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    conv_end && !state_reg.ctrl.result_hold_enable |=>
      state_reg.stat[0] && state_reg.result == $past(sat_code)
  ) else $error("conversion end did not set done with result");

  done_sticky_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.stat[0] && !done_wr |=> state_reg.stat[0]
  ) else $error("done flag cleared without software");

  hold_freeze_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.ctrl.result_hold_enable && !state_reg.stat[0] && !done_wr
      |=> $stable(state_reg.result) && !state_reg.stat[0]
  ) else $error("result or flag moved while held");

  bytes_sync_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(state_reg.result) |-> $past(conv_end) && state_reg.stat[0]
  ) else $error("result bytes changed apart from done");

  restart_flt_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(state_reg.ctrl.converter_restart) &&
      !state_reg.ctrl.converter_power_off && !state_reg.ctrl.converter_sleep
      |=> filter_reset ##1 (filter_reset || state_reg.mode == ARO_RUN)
  ) else $error("restart did not reset the filter");

  run_stay_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.mode == ARO_RUN && state_reg.ctrl == $past(state_reg.ctrl) &&
      !state_reg.ctrl.converter_power_off &&
      !state_reg.ctrl.converter_sleep && !state_reg.ctrl.converter_restart &&
      !(av_req.write && state_reg.ack && av_req.address == ARO_OFF_CTRL)
      |=> state_reg.mode == ARO_RUN [*2]
  ) else $error("continuous conversion stopped");

  rate_10hz_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    conv_end && state_reg.ctrl.output_rate_select == 3'h1 &&
      state_reg.ctrl.filter_mode_select == 3'h0
      |-> state_reg.cnt == LAST_10HZ
  ) else $error("10 Hz conversion length wrong");

  bus_wait_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req && !state_reg.ack |-> av_rsp.waitrequest ##1 !av_rsp.waitrequest
  ) else $error("access not answered in two cycles");

  // power modes, restart and timer
  off_quiet_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.ctrl.converter_power_off |=> !pga_enable && !modulator_enable
  ) else $error("converter still powered while off");

  wake_up_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.mode == ARO_OFF && !state_reg.ctrl.converter_power_off &&
      !state_reg.ctrl.converter_sleep && !state_reg.ctrl.converter_restart
      |=> pga_enable && !modulator_enable
  ) else $error("power off cleared without waking the amplifier");

  sleep_idle_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.mode == ARO_SLEEP && !state_reg.ctrl.converter_power_off &&
      !state_reg.ctrl.converter_restart |=> state_reg.mode != ARO_RUN
  ) else $error("conversion began without a restart pulse");

  restart_zero_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.mode == ARO_RESTART |=> state_reg.cnt == 24'h0
  ) else $error("restart left the conversion timer running");

  conv_gap_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    conv_end |=> !conv_end && state_reg.cnt == 24'h0
  ) else $error("conversion timer did not start over");

  // flags and interrupt
  clip_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    conv_end && !state_reg.ctrl.result_hold_enable && sat_clip
      |=> state_reg.stat[ARO_EV_CLIP]
  ) else $error("clamped result did not flag");

  done_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    done_wr && !conv_end |=> !state_reg.stat[ARO_EV_DONE]
  ) else $error("software clear of done ignored");

  hold_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg.ctrl.result_hold_enable && state_reg.stat == 2'h0 |=> !irq
  ) else $error("interrupt raised while results held");

  done_irq_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    conv_end && !state_reg.ctrl.result_hold_enable &&
      state_reg.mask[ARO_EV_DONE] &&
      !(av_req.write && state_reg.ack && av_req.address == ARO_OFF_MASK)
      |=> irq
  ) else $error("conversion end raised no interrupt");

  // register readback and control
  rd_low_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req && av_req.read && !state_reg.ack && av_req.address == ARO_OFF_RES_L
      |=> av_rsp.readdata == {24'h0, $past(state_reg.result[7:0])}
  ) else $error("low result byte read back wrong");

  rd_high_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    req && av_req.read && !state_reg.ack && av_req.address == ARO_OFF_RES_H
      |=> av_rsp.readdata[7:4] == {4{$past(state_reg.result[19])}}
  ) else $error("high result byte lost the sign");

  ctrl_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    av_req.write && state_reg.ack && av_req.address == ARO_OFF_CTRL &&
      av_req.byteenable[0]
      |=> state_reg.ctrl[7:0] == $past(av_req.writedata[7:0])
  ) else $error("control write did not land");

endmodule

`default_nettype wire

/* verif/tb_aro_result_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_aro_result_ctrl;
  import aro_pkg::*;

  logic mclk;
  logic rst_n;
  aro_av_req_type av_req;
  aro_av_rsp_type av_rsp;
  logic [23:0] filter_data;
  logic filter_reset;
  logic modulator_enable;
  logic pga_enable;
  logic irq;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] q;

  // short periods keep the run brief; expectations use these same figures
  aro_result_ctrl #(.PERIOD_10HZ(20), .PERIOD_OTHER(12)) i_aro_result_ctrl (
    .mclk(mclk),
    .rst_n(rst_n),
    .av_req(av_req),
    .av_rsp(av_rsp),
    .filter_data(filter_data),
    .filter_reset(filter_reset),
    .modulator_enable(modulator_enable),
    .pga_enable(pga_enable),
    .irq(irq)
  );

  // 125 MHz clock and a free cycle count for period measurement
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one avalon access; the request is held until the rising edge at which
  // waitrequest is seen low, and read data is taken and released there
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    av_req <= '{a, ~w, w, 4'h3, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 50);
    if (av_rsp.waitrequest !== 1'b0) bad_count++;
    q = av_rsp.readdata;
    av_req <= '0;
  endtask

  task wait_irq;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq !== 1'b1 && n < 100);
    if (irq !== 1'b1) bad_count++;
  endtask

  task t_reset;
    bus(0, ARO_OFF_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h001);
    bus(0, ARO_OFF_STAT, 32'h0);
    chk("stat reset", q, 32'h0);
    bus(0, 5'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("pga off", pga_enable, 32'h0);
    $display("test reset done");
  endtask

  // power up alone must not run; a restart pulse starts conversion
  task t_start;
    bus(1, ARO_OFF_CTRL, 32'h010);
    repeat (3) @(posedge mclk);
    chk("pga on", pga_enable, 32'h1);
    chk("no run yet", modulator_enable, 32'h0);
    bus(1, ARO_OFF_CTRL, 32'h014);
    repeat (2) @(posedge mclk);
    chk("filter reset", filter_reset, 32'h1);
    bus(1, ARO_OFF_CTRL, 32'h010);
    repeat (2) @(posedge mclk);
    chk("filter run", filter_reset, 32'h0);
    chk("mod run", modulator_enable, 32'h1);
    $display("test start done");
  endtask

  // data changed before the status clear, so any done after the clear is a new sample
  task t_conv(input logic [23:0] fd, input logic [19:0] exp, input logic clip);
    int n;
    filter_data <= fd;
    bus(1, ARO_OFF_CTRL, 32'h010);
    bus(1, ARO_OFF_STAT, 32'h3);
    n = 0;
    do begin
      bus(0, ARO_OFF_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    chk("status", q, {30'h0, clip, 1'b1});
    bus(1, ARO_OFF_CTRL, 32'h018);
    bus(0, ARO_OFF_RES_L, 32'h0);
    chk("low byte", q[7:0], exp[7:0]);
    bus(0, ARO_OFF_RES_M, 32'h0);
    chk("mid byte", q[7:0], exp[15:8]);
    bus(0, ARO_OFF_RES_H, 32'h0);
    chk("high byte", q[7:0], {{4{exp[19]}}, exp[19:16]});
    $display("test conversion %h done", fd);
  endtask

  // hold is on: a newer sample must be dropped with no flag and no irq
  task t_hold;
    filter_data <= 24'h000055;
    bus(1, ARO_OFF_MASK, 32'h3);
    bus(1, ARO_OFF_STAT, 32'h3);
    repeat (50) @(posedge mclk);
    bus(0, ARO_OFF_STAT, 32'h0);
    chk("held stat", q, 32'h0);
    chk("held irq", irq, 32'h0);
    bus(0, ARO_OFF_RES_L, 32'h0);
    chk("held low", q[7:0], 32'h00);
    bus(0, ARO_OFF_RES_H, 32'h0);
    chk("held high", q[7:0], 32'hf8);
    bus(1, ARO_OFF_MASK, 32'h0);
    $display("test hold done");
  endtask

  // second interval is measured so a rate change mid-count cannot skew it
  task t_rate(input logic [31:0] ctrl, input int per);
    int t0;
    bus(1, ARO_OFF_CTRL, ctrl);
    bus(1, ARO_OFF_MASK, 32'h1);
    bus(1, ARO_OFF_STAT, 32'h3);
    wait_irq;
    for (int k = 0; k < 2; k++) begin
      t0 = cyc;
      bus(1, ARO_OFF_STAT, 32'h1);
      wait_irq;
    end
    chk("period", cyc - t0, per);
    repeat (30) @(negedge mclk);
    chk("irq sticky", irq, 32'h1);
    bus(1, ARO_OFF_MASK, 32'h0);
    @(negedge mclk);
    chk("irq masked", irq, 32'h0);
    bus(0, ARO_OFF_STAT, 32'h0);
    chk("done kept", q[0], 32'h1);
    $display("test rate %h done", ctrl);
  endtask

  // sleep keeps the amplifier up with the modulator stopped; leaving it
  // needs a restart pulse, and power off drops both
  task t_sleep;
    bus(1, ARO_OFF_CTRL, 32'h012);
    repeat (3) @(posedge mclk);
    chk("sleep pga", pga_enable, 32'h1);
    chk("sleep mod", modulator_enable, 32'h0);
    bus(1, ARO_OFF_CTRL, 32'h010);
    repeat (3) @(posedge mclk);
    chk("wake no run", modulator_enable, 32'h0);
    bus(1, ARO_OFF_CTRL, 32'h011);
    repeat (3) @(posedge mclk);
    chk("off pga", pga_enable, 32'h0);
    chk("off mod", modulator_enable, 32'h0);
    $display("test sleep done");
  endtask

  initial begin
    rst_n = 1'b0;
    av_req = '0;
    filter_data = '0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_start;
    t_conv(24'h001234, 20'h01234, 1'b0);
    t_conv(24'hfffffe, 20'hffffe, 1'b0);
    t_conv(24'h080000, 20'h7ffff, 1'b1);
    t_conv(24'h07ffff, 20'h7ffff, 1'b0);
    t_conv(24'hf7ffff, 20'h80000, 1'b1);
    t_conv(24'hf80000, 20'h80000, 1'b0);
    t_hold;
    t_rate(32'h010, 20);
    t_rate(32'h020, 12);
    t_rate(32'h110, 12);
    t_sleep;
    complete_run;
  end

  // the tests need well under a thousand cycles; this bound is far beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run;
  end

endmodule

`default_nettype wire
